/* File: adc_cfg_map.svh */
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
// How it works
// - power mode writes wait in shadow until transfer command
// - transfer bit clears itself after the update
// - reset loads documented defaults, config 0x18
// - lsb-first set: lsb shifted, address increments
// - lsb-first clear: msb shifted, address decrements
// - soft reset bit clears port registers, self-clears
// - read-only chip identifier at address 0x001
// - power mode 00 normal, 01 power-down
// - mode 10 stops datapath clocks, link stays
// - mode 11 holds datapath and link in reset
// - pll status bit 7 shows lock
// - power-up bit order is msb first

// ----------------------------------------------------------------
// register offsets in the 13-bit serial address space
// ----------------------------------------------------------------
`define CFG_ADDR       13'h0000
`define CHIPID_ADDR    13'h0001
`define GRADE_ADDR     13'h0002
`define PWR_ADDR       13'h0008
`define PLL_ADDR       13'h000A
`define XFER_ADDR      13'h00FF

// ----------------------------------------------------------------
// field positions, reset values and masks
// ----------------------------------------------------------------
`define CFG_RST        8'h18
`define CFG_ADDR13_MSK 8'h18
`define CFG_LSB_HI     6
`define CFG_LSB_LO     1
`define CFG_SRST_HI    5
`define CFG_SRST_LO    2
`define GRADE_VAL      8'h14
`define PWR_RST        8'h80
`define PWR_KEEP_MSK   8'h80
`define PWR_MODE_RST   2'h0
`define PLL_LOCK_BIT   7
`define XFER_CMD_BIT   0
`define RD_NONE        8'h00

// ----------------------------------------------------------------
// power mode codes
// ----------------------------------------------------------------
`define PM_CODE_NORMAL 2'h0
`define PM_CODE_DOWN   2'h1
`define PM_CODE_STBY   2'h2
`define PM_CODE_DPRST  2'h3

// ----------------------------------------------------------------
// serial framing counts
// ----------------------------------------------------------------
`define INSTR_LAST     4'hF
`define BYTE_LAST      4'h7
`define INSTR_RW_BIT   15
`define ADDR_MSB       12
`endif

/* File: adc_cfg_pkg.sv */
package adc_cfg_pkg;
  // serial port framing phases, one-hot
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h1,
    PH_INSTR = 3'h2,
    PH_DATA  = 3'h4
  } spi_phase_t;
  // applied power state, one-hot
  typedef enum logic [3:0] {
    PM_NORMAL  = 4'h1,
    PM_DOWN    = 4'h2,
    PM_STANDBY = 4'h4,
    PM_DPRESET = 4'h8
  } pwr_state_t;
endpackage

/* File: spi_reg_if.sv */
`timescale 1ns/1ps
// register access between serial engine and register bank
interface spi_reg_if;
  logic        wr;         // one-cycle write strobe
  logic [12:0] waddr;      // write address
  logic [7:0]  wdata;      // write byte
  logic [12:0] raddr;      // read address
  logic [7:0]  rdata;      // read byte, combinational
  logic        lsb_first;  // bit order and address direction
  modport engine (output wr, waddr, wdata, raddr, input rdata, lsb_first);
  modport bank   (input wr, waddr, wdata, raddr, output rdata, lsb_first);
endinterface

/* File: spi_serial_engine.sv */
`timescale 1ns/1ps
`include "adc_cfg_map.svh"
module spi_serial_engine
  import adc_cfg_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_reset,
  input  wire logic  i_clk_en,
  input  wire logic  i_sclk,
  input  wire logic  i_csb,
  input  wire logic  i_sdio,
  output logic       o_sdio,
  output logic       o_sdio_oe,
  spi_reg_if.engine  bus
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spi_phase_t  phase_r;     // framing phase
  logic        sclk_q;      // previous serial clock level
  logic [3:0]  cnt_r;       // bit count within phase
  logic [15:0] ish_r;       // instruction shifter
  logic [7:0]  dsh_r;       // data shifter
  logic [7:0]  tx_r;        // read data shifter
  logic        rw_r;        // 1 = read frame
  logic [12:0] addr_r;      // current streaming address
  logic        load_r;      // fetch read byte next cycle
  logic        sclk_rise;
  logic        sclk_fall;
  logic        instr_done;
  logic        byte_done;
  logic [15:0] ish_nxt;
  logic [7:0]  dsh_nxt;

  // sclk is sampled like any input, so it must run well below the ref clock
  assign sclk_rise  = i_sclk & ~sclk_q;
  assign sclk_fall  = ~i_sclk & sclk_q;
  assign instr_done = (phase_r == PH_INSTR) && sclk_rise && (cnt_r == `INSTR_LAST);
  assign byte_done  = (phase_r == PH_DATA) && sclk_rise && (cnt_r == `BYTE_LAST);
  // shift direction follows the configured bit order
  assign ish_nxt = bus.lsb_first ? {i_sdio, ish_r[15:1]} : {ish_r[14:0], i_sdio};
  assign dsh_nxt = bus.lsb_first ? {i_sdio, dsh_r[7:1]} : {dsh_r[6:0], i_sdio};
  assign bus.raddr = addr_r;

  // edge detector; parks at the idle high level of sclk so no false rise follows reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) sclk_q <= 1'b1;
    else if (i_clk_en) sclk_q <= i_sclk;
  end

  // framing phase and bit counter; chip select high aborts any frame
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      phase_r <= PH_IDLE;
      cnt_r   <= 4'h0;
    end else if (i_clk_en) begin
      if (i_csb) begin
        phase_r <= PH_IDLE;
        cnt_r   <= 4'h0;
      end else begin
        case (phase_r)
          PH_IDLE: begin
            phase_r <= PH_INSTR;
            cnt_r   <= 4'h0;
          end
          PH_INSTR: if (sclk_rise) begin
            if (cnt_r == `INSTR_LAST) begin
              phase_r <= PH_DATA;
              cnt_r   <= 4'h0;
            end else cnt_r <= cnt_r + 4'h1;
          end
          PH_DATA: if (sclk_rise) begin
            cnt_r <= (cnt_r == `BYTE_LAST) ? 4'h0 : cnt_r + 4'h1;
          end
          default: phase_r <= PH_IDLE;
        endcase
      end
    end
  end

  // input shifters
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ish_r <= 16'h0000;
      dsh_r <= 8'h00;
    end else if (i_clk_en) begin
      if (phase_r == PH_INSTR && sclk_rise) ish_r <= ish_nxt;
      if (phase_r == PH_DATA && sclk_rise) dsh_r <= dsh_nxt;
    end
  end

  // address: loaded by the instruction, stepped after every byte
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rw_r   <= 1'b0;
      addr_r <= 13'h0000;
    end else if (i_clk_en) begin
      if (instr_done) begin
        rw_r   <= ish_nxt[`INSTR_RW_BIT];
        addr_r <= ish_nxt[`ADDR_MSB:0];
      end else if (byte_done) begin
        addr_r <= bus.lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
      end
    end
  end

  // write strobe carries the address the byte belonged to
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bus.wr    <= 1'b0;
      bus.waddr <= 13'h0000;
      bus.wdata <= 8'h00;
    end else if (i_clk_en) begin
      bus.wr <= byte_done && !rw_r;
      if (byte_done && !rw_r) begin
        bus.waddr <= addr_r;
        bus.wdata <= dsh_nxt;
      end
    end
  end

  // read byte fetched one cycle after the address settles
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      load_r <= 1'b0;
      tx_r   <= 8'h00;
    end else if (i_clk_en) begin
      load_r <= (instr_done && ish_nxt[`INSTR_RW_BIT]) || (byte_done && rw_r);
      if (load_r) tx_r <= bus.rdata;
      else if (phase_r == PH_DATA && rw_r && sclk_fall)
        tx_r <= bus.lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // sdio driven on falling edges during the data phase of a read
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_sdio    <= 1'b0;
      o_sdio_oe <= 1'b0;
    end else if (i_clk_en) begin
      if (i_csb || phase_r != PH_DATA || !rw_r) begin
        o_sdio_oe <= 1'b0;
      end else if (sclk_fall) begin
        o_sdio    <= bus.lsb_first ? tx_r[0] : tx_r[7];
        o_sdio_oe <= 1'b1;
      end
    end
  end
endmodule

/* File: adc_config_register_bank.sv */
`timescale 1ns/1ps
`include "adc_cfg_map.svh"
module adc_config_register_bank
  import adc_cfg_pkg::*;
#(
  // identifier value is arbitrary, not that of any product
  parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_sclk,
  input  wire logic i_csb,
  input  wire logic i_sdio,
  input  wire logic i_pll_locked,
  output logic      o_sdio,
  output logic      o_sdio_oe,
  output logic      o_power_down,
  output logic      o_dp_clk_stop,
  output logic      o_dp_reset,
  output logic      o_link_reset,
  output logic      o_outputs_en
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // address match, shared by write and read decode
  function automatic logic hit(input logic [12:0] a, input logic [12:0] loc);
    hit = (a == loc);
  endfunction

  // power code to one-hot applied state
  function automatic pwr_state_t pwr_decode(input logic [1:0] code);
    case (code)
      `PM_CODE_NORMAL: pwr_decode = PM_NORMAL;
      `PM_CODE_DOWN:   pwr_decode = PM_DOWN;
      `PM_CODE_STBY:   pwr_decode = PM_STANDBY;
      `PM_CODE_DPRST:  pwr_decode = PM_DPRESET;
      default:         pwr_decode = PM_NORMAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  spi_reg_if   bus_if ();      // engine to bank link
  logic        lsb_r;          // bit order, mirrored in two bits
  logic        srst_r;         // pending soft reset, lives one cycle
  logic [1:0]  pwr_shadow_r;   // power code as written
  logic [1:0]  pwr_active_r;   // power code in effect
  logic        xfer_r;         // transfer pending
  pwr_state_t  pstate_r;       // decoded applied power state
  logic        wr_en;          // qualified write strobe
  logic        wr_cfg;         // write hits port config
  logic        wr_pwr;         // write hits power control
  logic        wr_xfer_set;    // transfer command seen
  logic [7:0]  rd_cfg;         // port config as read back
  logic [7:0]  rd_byte;        // read mux result

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  spi_serial_engine u_engine (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .i_sclk    (i_sclk),
    .i_csb     (i_csb),
    .i_sdio    (i_sdio),
    .o_sdio    (o_sdio),
    .o_sdio_oe (o_sdio_oe),
    .bus       (bus_if)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // unmapped addresses fall through every hit and are simply dropped
  assign wr_en       = bus_if.wr && i_clk_en;
  assign wr_cfg      = wr_en && hit(bus_if.waddr, `CFG_ADDR);
  assign wr_pwr      = wr_en && hit(bus_if.waddr, `PWR_ADDR);
  assign wr_xfer_set = wr_en && hit(bus_if.waddr, `XFER_ADDR)
                       && bus_if.wdata[`XFER_CMD_BIT];
  assign bus_if.lsb_first = lsb_r;

  // ----------------------------------------------------------------
  // serial port configuration
  // ----------------------------------------------------------------
  // either mirrored bit sets the order; soft reset wins one cycle later
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lsb_r  <= 1'b0;
      srst_r <= 1'b0;
    end else if (i_clk_en) begin
      if (srst_r) begin
        lsb_r  <= 1'b0;
        srst_r <= 1'b0;
      end else if (wr_cfg) begin
        lsb_r  <= bus_if.wdata[`CFG_LSB_HI] | bus_if.wdata[`CFG_LSB_LO];
        srst_r <= bus_if.wdata[`CFG_SRST_HI] | bus_if.wdata[`CFG_SRST_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // power control shadow and transfer
  // ----------------------------------------------------------------
  // shadow only takes the mode field; reserved bits are not stored
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) pwr_shadow_r <= `PWR_MODE_RST;
    else if (wr_pwr) pwr_shadow_r <= bus_if.wdata[1:0];
  end

  // transfer flag: a new command in the clearing cycle keeps it set
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) xfer_r <= 1'b0;
    else if (i_clk_en) begin
      if (wr_xfer_set) xfer_r <= 1'b1;
      else if (xfer_r) xfer_r <= 1'b0;
    end
  end

  // every shadowed field moves into effect in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwr_active_r <= `PWR_MODE_RST;
      pstate_r     <= PM_NORMAL;
    end else if (i_clk_en && xfer_r) begin
      pwr_active_r <= pwr_shadow_r;
      pstate_r     <= pwr_decode(pwr_shadow_r);
    end
  end

  // ----------------------------------------------------------------
  // power mode outputs
  // ----------------------------------------------------------------
  // registered one cycle behind the applied state to keep outputs clean
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_power_down  <= 1'b0;
      o_dp_clk_stop <= 1'b0;
      o_dp_reset    <= 1'b0;
      o_link_reset  <= 1'b0;
      o_outputs_en  <= 1'b1;
    end else if (i_clk_en) begin
      case (pstate_r)
        PM_NORMAL: begin
          o_power_down  <= 1'b0;
          o_dp_clk_stop <= 1'b0;
          o_dp_reset    <= 1'b0;
          o_link_reset  <= 1'b0;
          o_outputs_en  <= 1'b1;
        end
        PM_DOWN: begin
          o_power_down  <= 1'b1;
          o_dp_clk_stop <= 1'b1;
          o_dp_reset    <= 1'b0;
          o_link_reset  <= 1'b0;
          o_outputs_en  <= 1'b0;
        end
        PM_STANDBY: begin
          o_power_down  <= 1'b0;
          o_dp_clk_stop <= 1'b1;
          o_dp_reset    <= 1'b0;
          o_link_reset  <= 1'b0;
          o_outputs_en  <= 1'b1;
        end
        PM_DPRESET: begin
          o_power_down  <= 1'b0;
          o_dp_clk_stop <= 1'b0;
          o_dp_reset    <= 1'b1;
          o_link_reset  <= 1'b1;
          o_outputs_en  <= 1'b1;
        end
        default: begin
          o_power_down  <= 1'b0;
          o_dp_clk_stop <= 1'b0;
          o_dp_reset    <= 1'b0;
          o_link_reset  <= 1'b0;
          o_outputs_en  <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // soft reset bits always read zero; 13-bit addressing bits read one
  always_comb begin
    rd_cfg = `CFG_ADDR13_MSK;
    rd_cfg[`CFG_LSB_HI] = lsb_r;
    rd_cfg[`CFG_LSB_LO] = lsb_r;
  end

  // unmapped and reserved locations read zero
  always_comb begin
    rd_byte = `RD_NONE;
    if (hit(bus_if.raddr, `CFG_ADDR)) rd_byte = rd_cfg;
    else if (hit(bus_if.raddr, `CHIPID_ADDR)) rd_byte = CHIP_IDENTIFIER;
    else if (hit(bus_if.raddr, `GRADE_ADDR)) rd_byte = `GRADE_VAL;
    else if (hit(bus_if.raddr, `PWR_ADDR)) rd_byte = `PWR_KEEP_MSK | {6'h00, pwr_shadow_r};
    else if (hit(bus_if.raddr, `PLL_ADDR)) rd_byte[`PLL_LOCK_BIT] = i_pll_locked;
    else if (hit(bus_if.raddr, `XFER_ADDR)) rd_byte[`XFER_CMD_BIT] = xfer_r;
  end
  assign bus_if.rdata = rd_byte;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_xfer_cmd;
    wr_xfer_set;
  endsequence

  sequence s_apply;
    i_clk_en && xfer_r;
  endsequence

  property p_xfer_apply;
    @(posedge i_ref_clk) disable iff (i_reset)
      s_xfer_cmd ##1 s_apply |=> (pwr_active_r == $past(pwr_shadow_r));
  endproperty
  a_xfer_apply: assert property (p_xfer_apply) else $error("transfer did not apply shadow");

  property p_shadow_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
      !xfer_r |=> $stable(pwr_active_r);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active mode moved without transfer");

  property p_xfer_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
      s_apply and !wr_xfer_set |=> !xfer_r;
  endproperty
  a_xfer_clear: assert property (p_xfer_clear) else $error("transfer bit did not self clear");

  property p_reset_vals;
    @(posedge i_ref_clk)
      i_reset |=> (rd_cfg == `CFG_RST) && (pwr_active_r == `PWR_MODE_RST) && o_outputs_en;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong");

  property p_lsb_set;
    @(posedge i_ref_clk) disable iff (i_reset)
      wr_cfg && !srst_r && bus_if.wdata[`CFG_LSB_LO] && !bus_if.wdata[`CFG_SRST_HI]
      && !bus_if.wdata[`CFG_SRST_LO] |=> bus_if.lsb_first;
  endproperty
  a_lsb_set: assert property (p_lsb_set) else $error("lsb first not taken");

  property p_msb_set;
    @(posedge i_ref_clk) disable iff (i_reset)
      wr_cfg && !srst_r && !bus_if.wdata[`CFG_LSB_LO] && !bus_if.wdata[`CFG_LSB_HI] |=> !bus_if.lsb_first;
  endproperty
  a_msb_set: assert property (p_msb_set) else $error("msb first not taken");

  property p_soft_reset;
    @(posedge i_ref_clk) disable iff (i_reset)
      wr_cfg && (bus_if.wdata[`CFG_SRST_HI] || bus_if.wdata[`CFG_SRST_LO]) && !srst_r
      ##1 i_clk_en |=> !lsb_r && !srst_r;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not act or clear");

  property p_chip_identifier;
    @(posedge i_ref_clk) disable iff (i_reset)
      hit(bus_if.raddr, `CHIPID_ADDR) |-> (bus_if.rdata == CHIP_IDENTIFIER);
  endproperty
  a_chip_identifier: assert property (p_chip_identifier) else $error("chip identifier wrong");

  property p_pll;
    @(posedge i_ref_clk) disable iff (i_reset)
      hit(bus_if.raddr, `PLL_ADDR) |-> (bus_if.rdata[`PLL_LOCK_BIT] == i_pll_locked);
  endproperty
  a_pll: assert property (p_pll) else $error("pll lock bit wrong");

  property p_pwr_down;
    @(posedge i_ref_clk) disable iff (i_reset)
      i_clk_en && pstate_r == PM_DOWN |=> o_power_down && !o_outputs_en;
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("power down not driven");

  property p_standby;
    @(posedge i_ref_clk) disable iff (i_reset)
      i_clk_en && pstate_r == PM_STANDBY |=> o_dp_clk_stop && !o_link_reset && o_outputs_en;
  endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong");

  property p_dp_reset;
    @(posedge i_ref_clk) disable iff (i_reset)
      i_clk_en && pstate_r == PM_DPRESET |=> o_dp_reset && o_link_reset && !o_dp_clk_stop;
  endproperty
  a_dp_reset: assert property (p_dp_reset) else $error("datapath reset outputs wrong");
endmodule

/* File: spi_host_model.sv */
`timescale 1ns/1ps
`include "adc_cfg_map.svh"
// ----------------------------------------------------------------
// serial host: frames bits at a slow sclk, releases sdio when reading
// ----------------------------------------------------------------
module spi_host_model #(
  parameter int HALF = 5  // ref cycles per sclk half, above the 2 minimum
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_dev_sdio,
  input  wire logic i_dev_sdio_oe,
  output logic      o_sclk,
  output logic      o_csb,
  output logic      o_sdio_line
);
  logic       host_bit;   // bit the host puts on the wire
  logic       host_oe;    // host drives the wire
  logic       last_lvl = 1'b0; // last wire level, inverted when floating
  logic [7:0] wbuf [4];   // bytes to send
  logic [7:0] rbuf [4];   // bytes received

  // no pull on sdio: a floating wire toggles so it never looks stable
  assign o_sdio_line = i_dev_sdio_oe ? i_dev_sdio : (host_oe ? host_bit : ~last_lvl);
  always @(posedge i_ref_clk) last_lvl <= o_sdio_line;

  // idle: clock parked high, chip select high, wire released
  initial begin
    o_sclk   = 1'b1;
    o_csb    = 1'b1;
    host_oe  = 1'b0;
    host_bit = 1'b0;
  end

  // writable bits of each mapped address, zero means never written
  function automatic logic [7:0] wmask(input logic [12:0] a);
    case (a)
      `CFG_ADDR:  return 8'h66;
      `PWR_ADDR:  return 8'h03;
      `XFER_ADDR: return 8'h01;
      default:    return 8'h00;
    endcase
  endfunction

  // one bit per sclk period, changed on the fall, sampled before the rise
  task automatic shift(input logic [15:0] v, input int n, input logic lsb, input logic drv,
                       output logic [15:0] r);
    int idx;
    r = 16'h0000;
    for (int i = 0; i < n; i++) begin
      idx = lsb ? i : n - 1 - i;
      @(negedge i_ref_clk);
      o_sclk   = 1'b0;
      host_oe  = drv;
      host_bit = v[idx];
      repeat (HALF) @(negedge i_ref_clk);
      r[idx] = o_sdio_line;
      o_sclk = 1'b1;
      repeat (HALF - 1) @(negedge i_ref_clk);
    end
  endtask

  // whole frame: instruction then n bytes, csb held low throughout
  task automatic frame(input logic rd, input logic [12:0] addr, input int n, input logic lsb);
    logic [15:0] r;
    if (!rd && wmask(addr) == 8'h00) return;
    @(negedge i_ref_clk);
    o_csb = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    shift({rd, 2'b00, addr}, 16, lsb, 1'b1, r);
    for (int b = 0; b < n; b++) begin
      shift({8'h00, wbuf[b] & wmask(addr)}, 8, lsb, !rd, r);
      rbuf[b] = r[7:0];
    end
    repeat (2) @(negedge i_ref_clk);
    o_csb   = 1'b1;
    host_oe = 1'b0;
    repeat (4) @(negedge i_ref_clk);
  endtask
endmodule

/* File: test_adc_config_register_bank.sv */
`timescale 1ns/1ps
`include "adc_cfg_map.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module test_adc_config_register_bank;
  localparam logic [7:0] ID = 8'hC3;  // arbitrary identifier for the run
  logic        i_ref_clk = 1'b0;      // 50 MHz clock
  logic        i_reset   = 1'b1;      // sync reset, active high
  logic        pll_lock  = 1'b0;      // lock level fed to the bank
  logic        clk_en    = 1'b1;      // clock enable, low freezes the bank
  logic        sclk, csb, sdio_line;  // serial wires from the host
  logic        dev_sdio, dev_oe;      // device side of sdio
  logic        pd, clk_stop, dp_rst, link_rst, out_en;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  logic [31:0] seed      = 32'hD032744C;
  logic [1:0]  m, prev;

  always #10 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------
  adc_config_register_bank #(.CHIP_IDENTIFIER(ID)) uut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(clk_en), .i_sclk(sclk),
    .i_csb(csb), .i_sdio(sdio_line), .i_pll_locked(pll_lock), .o_sdio(dev_sdio),
    .o_sdio_oe(dev_oe), .o_power_down(pd), .o_dp_clk_stop(clk_stop),
    .o_dp_reset(dp_rst), .o_link_reset(link_rst), .o_outputs_en(out_en));
  spi_host_model host (
    .i_ref_clk(i_ref_clk), .i_dev_sdio(dev_sdio), .i_dev_sdio_oe(dev_oe),
    .o_sclk(sclk), .o_csb(csb), .o_sdio_line(sdio_line));

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // applied mode to {power_down, clk_stop, dp_reset, link_reset, outputs_en}
  function automatic logic [4:0] mode_out(input logic [1:0] md);
    return {md == 2'h1, md == 2'h1 || md == 2'h2, md == 2'h3, md == 2'h3, md != 2'h1};
  endfunction

  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
    host.wbuf[0] = d;
    host.frame(1'b0, a, 1, lsb);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e, input logic lsb);
    host.frame(1'b1, a, 1, lsb);
    `CHK(host.rbuf[0], e)
  endtask
  task automatic mode_chk(input logic [1:0] md);
    `CHK({pd, clk_stop, dp_rst, link_rst, out_en}, mode_out(md))
  endtask

  // verdict in one place; a hang lands here too
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ceiling well above the ~20k cycles the frames need
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_reset = 1'b0;
    mode_chk(2'h0);
    rd_chk(`CFG_ADDR, 8'h18, 1'b0);
    rd_chk(`CHIPID_ADDR, ID, 1'b0);
    rd_chk(`GRADE_ADDR, 8'h14, 1'b0);
    rd_chk(`PWR_ADDR, 8'h80, 1'b0);
    rd_chk(13'h0003, 8'h00, 1'b0);
    // every mode first, then random ones; pll level random throughout
    prev = 2'h0;
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      m = (i < 4) ? i[1:0] : seed[1:0];
      pll_lock = seed[8];
      wr(`PWR_ADDR, {6'h00, m}, 1'b0);
      mode_chk(prev);
      rd_chk(`PWR_ADDR, 8'h80 | m, 1'b0);
      wr(`XFER_ADDR, 8'h01, 1'b0);
      repeat (3) @(negedge i_ref_clk);
      mode_chk(m);
      rd_chk(`XFER_ADDR, 8'h00, 1'b0);
      rd_chk(`PLL_ADDR, {pll_lock, 7'h00}, 1'b0);
      prev = m;
    end
    // clock enable low freezes the bank: frames sent meanwhile are lost
    clk_en = 1'b0;
    wr(`PWR_ADDR, {6'h00, ~prev}, 1'b0);
    wr(`XFER_ADDR, 8'h01, 1'b0);
    clk_en = 1'b1;
    mode_chk(prev);
    rd_chk(`PWR_ADDR, 8'h80 | prev, 1'b0);
    // msb first streams downward through the chip registers
    host.frame(1'b1, `GRADE_ADDR, 3, 1'b0);
    `CHK({host.rbuf[0], host.rbuf[1], host.rbuf[2]}, {8'h14, ID, 8'h18})
    // lsb first streams upward
    wr(`CFG_ADDR, 8'h42, 1'b0);
    host.frame(1'b1, `CFG_ADDR, 3, 1'b1);
    `CHK({host.rbuf[0], host.rbuf[1], host.rbuf[2]}, {8'h5A, ID, 8'h14})
    // soft reset through each bit beats the lsb bits written with it
    wr(`CFG_ADDR, 8'h62, 1'b1);
    rd_chk(`CFG_ADDR, 8'h18, 1'b0);
    wr(`CFG_ADDR, 8'h42, 1'b0);
    rd_chk(`CFG_ADDR, 8'h5A, 1'b1);
    wr(`CFG_ADDR, 8'h46, 1'b1);
    rd_chk(`CFG_ADDR, 8'h18, 1'b0);
    // second reset mid-run restores the defaults
    wr(`PWR_ADDR, 8'h03, 1'b0);
    wr(`XFER_ADDR, 8'h01, 1'b0);
    wr(`CFG_ADDR, 8'h42, 1'b0);
    i_reset = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 1'b0;
    mode_chk(2'h0);
    rd_chk(`CFG_ADDR, 8'h18, 1'b0);
    rd_chk(`PWR_ADDR, 8'h80, 1'b0);
    complete_run();
  end
endmodule
